// [design/vtcf_pkg.sv]
// constants, field layouts and states of the vlan tag classify/forward block
// assumes one switch clock, synchronous active-low reset
package vtcf_pkg;
  localparam int NPORTS = 4;
  localparam int PORT_W = 2;
  localparam int VID_W = 12;
  localparam int NENTRIES = 256;
  localparam int IDX_W = 8;
  // frame layout
  localparam logic [15:0] TPID = 16'h8100;
  localparam logic [4:0] SA_END = 5'h0C;
  localparam logic [4:0] TAG_END = 5'h10;
  localparam logic [4:0] TAG_BYTES = 5'h04;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam int HDR_BYTES = 16;
  localparam logic [2:0] DLY_FULL = 3'h4;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [4:0] LEN_STRIP = 5'h0C;
  localparam logic [4:0] LEN_KEEP = 5'h10;
  localparam logic [4:0] LEN_INSERT = 5'h14;
  // tag control information
  localparam logic [2:0] INS_PCP = 3'h0;
  localparam logic INS_CFI = 1'b0;
  localparam logic [11:0] DEFAULT_VID = 12'h001;
  localparam logic [11:0] VID_NULL = 12'h000;
  localparam logic [11:0] VID_RSVD = 12'hFFF;
  // configuration port map (word addresses)
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_PVID_END = 10'h004;
  localparam logic [9:0] ADDR_FRAMES = 10'h010;
  localparam logic [9:0] ADDR_DROPS = 10'h011;
  localparam logic [1:0] ADDR_TABLE_PAGE = 2'h1;
  localparam int ENT_VALID_BIT = 31;
  localparam int ENT_UNTAG_LSB = 20;
  localparam int ENT_MEMBER_LSB = 16;
  localparam logic [3:0] RST_MEMBERS = 4'hF;
  localparam logic [3:0] RST_UNTAG = 4'hF;
  // crc-32, reflected
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  // ingress fifo word
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 14;
  localparam int FW_SOP = 8;
  localparam int FW_EOP = 9;
  localparam int FW_EG_LSB = 10;
  localparam int FW_IN_LSB = 12;

  typedef enum logic [5:0] {
    S_HDR  = 6'b000001,
    S_LOOK = 6'b000010,
    S_EMIT = 6'b000100,
    S_BODY = 6'b001000,
    S_FCS  = 6'b010000,
    S_DROP = 6'b100000
  } vtcf_state_e;
endpackage : vtcf_pkg

// [design/vtcf_fifo.sv]
// synchronous fifo, flip-flop storage, valid/ready on both sides
// assumes depth of at least two; flags are registered
module vtcf_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [WIDTH-1:0] rdData,
  output logic rdValid,
  input wire logic rdReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = wrValid && wrReady;
  assign pop = rdValid && rdReady;
  assign rdData = mem[rdPtr];

  always_comb begin
    case ({push, pop})
      2'b10: next_count = count + 1'b1;
      2'b01: next_count = count - 1'b1;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      wrReady <= 1'b0;
      rdValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= next_count;
      wrReady <= (next_count != (AW + 1)'(DEPTH));
      rdValid <= (next_count != '0);
    end
  end
endmodule : vtcf_fifo

// [design/vtcf_crc32.sv]
// running ethernet crc-32 over emitted bytes, lsb first
// assumes clear is pulsed once before the first byte of a frame
module vtcf_crc32
  import vtcf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= crc_byte(crc, data);
    end
  end
endmodule : vtcf_crc32

// [design/vtcf_frame_proc.sv]
// vlan classify, membership filter and egress tag edit for one frame stream
// assumes bytes arrive with fcs attached and frames of at least 20 bytes
// Functional notes
// - an inserted tag adds four bytes right after the source address
// - a frame is tagged exactly when its ethertype equals 0x8100
// - tag control is 3-bit priority, 1-bit cfi, then 12-bit vlan id
// - inserted tag goes before the original ethertype/length, rest kept
// - fcs is recomputed whenever a tag is inserted or removed
// - all other frame bytes pass unchanged
// - untagged frames take the ingress port initial_vlan_group
// - tagged frames use the vlan id carried in their tag
// - frames whose vlan excludes the egress port are discarded
// - one initial_vlan_group per port, membership in many vlans via table
// - after reset vlan 1 holds all ports untagged, defaults all 1
// - creating a vlan removes its ports from the vlan 1 member list
// - vlan table holds at least 255 vlans
// - flooded and unknown frames reach only members of their vlan
// - per-port per-vlan egress setting strips or adds the tag
// - 12-bit vlan id, ids 0 and 4095 never match an entry
module vtcf_frame_proc
  import vtcf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] inData,
  input wire logic inValid,
  input wire logic inSop,
  input wire logic inEop,
  input wire logic [PORT_W-1:0] inPort,
  input wire logic [PORT_W-1:0] inEgress,
  output logic inReady,
  output logic [7:0] outData,
  output logic outValid,
  output logic outSop,
  output logic outEop,
  output logic [PORT_W-1:0] outPort,
  input wire logic outReady,
  input wire logic [ADDR_W-1:0] cfgAddr,
  input wire logic [31:0] cfgWdata,
  input wire logic cfgWr,
  input wire logic cfgRd,
  output logic [31:0] cfgRdata
);
  vtcf_state_e state;
  logic [FIFO_WIDTH-1:0] fifoWord;
  logic fifoValid;
  logic pop;
  logic [7:0] fData;
  logic fSop;
  logic fEop;
  logic [7:0] hdr [HDR_BYTES];
  logic [4:0] hcnt;
  logic [PORT_W-1:0] frmIn;
  logic [PORT_W-1:0] frmEg;
  logic [VID_W-1:0] pvid [NPORTS];
  logic entValid [NENTRIES];
  logic [VID_W-1:0] entVid [NENTRIES];
  logic [NPORTS-1:0] entMember [NENTRIES];
  logic [NPORTS-1:0] entUntag [NENTRIES];
  logic [NENTRIES-1:0] hit;
  logic rxTagged;
  logic [VID_W-1:0] rxVid;
  logic [NPORTS-1:0] rxMembers;
  logic [NPORTS-1:0] rxUntag;
  logic doStrip;
  logic doInsert;
  logic [4:0] emitLen;
  logic [VID_W-1:0] frmVid;
  logic [4:0] ecnt;
  logic [4:0] subIdx;
  logic [7:0] dly [4];
  logic [2:0] dcnt;
  logic [1:0] fcnt;
  logic [31:0] crcVal;
  logic [31:0] fcsWord;
  logic [15:0] tci;
  logic adv;
  logic fire;
  logic [7:0] emitB;
  logic next_outValid;
  logic [7:0] next_outData;
  logic next_outSop;
  logic next_outEop;
  logic [31:0] frames;
  logic [31:0] drops;
  logic tblWr;
  logic [IDX_W-1:0] tblIdx;
  logic createHit;

  // decouples the link from output stalls; its ready throttles the source
  vtcf_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wrData({inPort, inEgress, inEop, inSop, inData}),
    .wrValid(inValid),
    .wrReady(inReady),
    .rdData(fifoWord),
    .rdValid(fifoValid),
    .rdReady(pop)
  );

  assign fData = fifoWord[7:0];
  assign fSop = fifoWord[FW_SOP];
  assign fEop = fifoWord[FW_EOP];

  vtcf_crc32 u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(state == S_LOOK),
    .en(fire && state != S_FCS),
    .data(emitB),
    .crc(crcVal)
  );

  // classification
  assign rxTagged = ({hdr[12], hdr[13]} == TPID);
  assign rxVid = rxTagged ? {hdr[14][3:0], hdr[15]} : pvid[frmIn];

  genvar gi;
  generate
    for (gi = 0; gi < NENTRIES; gi++) begin : g_entry
      // reserved ids never classify into a vlan
      assign hit[gi] = entValid[gi] && entVid[gi] == rxVid && rxVid != VID_NULL && rxVid != VID_RSVD;

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          entValid[gi] <= (gi == 0);
          entVid[gi] <= (gi == 0) ? DEFAULT_VID : VID_NULL;
          entMember[gi] <= (gi == 0) ? RST_MEMBERS : '0;
          entUntag[gi] <= (gi == 0) ? RST_UNTAG : '0;
        end else if (tblWr && tblIdx == IDX_W'(gi)) begin
          entValid[gi] <= cfgWdata[ENT_VALID_BIT];
          entVid[gi] <= cfgWdata[VID_W-1:0];
          entMember[gi] <= cfgWdata[ENT_MEMBER_LSB +: NPORTS];
          entUntag[gi] <= cfgWdata[ENT_UNTAG_LSB +: NPORTS];
        end else if (gi == 0 && createHit) begin
          entMember[gi] <= entMember[gi] & ~cfgWdata[ENT_MEMBER_LSB +: NPORTS];
          entUntag[gi] <= entUntag[gi] & ~cfgWdata[ENT_MEMBER_LSB +: NPORTS];
        end
      end
    end
  endgenerate

  always_comb begin
    rxMembers = '0;
    rxUntag = '0;
    for (int i = 0; i < NENTRIES; i++) begin
      if (hit[i]) begin
        rxMembers = rxMembers | entMember[i];
        rxUntag = rxUntag | entUntag[i];
      end
    end
  end

  // configuration
  assign tblWr = cfgWr && cfgAddr[9:8] == ADDR_TABLE_PAGE;
  assign tblIdx = cfgAddr[IDX_W-1:0];
  assign createHit = tblWr && tblIdx != '0 && !entValid[tblIdx] && cfgWdata[ENT_VALID_BIT];

  generate
    for (gi = 0; gi < NPORTS; gi++) begin : g_pvid
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pvid[gi] <= DEFAULT_VID;
        end else if (cfgWr && cfgAddr == ADDR_W'(gi)) begin
          pvid[gi] <= cfgWdata[VID_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgRdata <= '0;
    end else if (cfgRd) begin
      if (cfgAddr[9:8] == ADDR_TABLE_PAGE) begin
        cfgRdata <= {entValid[tblIdx], 7'h00, entUntag[tblIdx], entMember[tblIdx], 4'h0, entVid[tblIdx]};
      end else if (cfgAddr < ADDR_PVID_END) begin
        cfgRdata <= {20'h00000, pvid[cfgAddr[PORT_W-1:0]]};
      end else if (cfgAddr == ADDR_FRAMES) begin
        cfgRdata <= frames;
      end else if (cfgAddr == ADDR_DROPS) begin
        cfgRdata <= drops;
      end else begin
        cfgRdata <= '0;
      end
    end else begin
      cfgRdata <= '0;
    end
  end

  // output byte selection
  assign tci = {INS_PCP, INS_CFI, frmVid};
  assign fcsWord = ~crcVal;
  assign subIdx = ecnt - TAG_BYTES;
  assign adv = !outValid || outReady;

  always_comb begin
    fire = 1'b0;
    pop = 1'b0;
    emitB = '0;
    case (state)
      S_HDR, S_DROP: begin
        pop = fifoValid;
      end
      S_EMIT: begin
        fire = adv;
        if (doInsert && ecnt >= TAG_END) begin
          emitB = hdr[subIdx[3:0]];
        end else if (doInsert && ecnt >= SA_END) begin
          case (subIdx[1:0])
            2'h0: emitB = TPID[15:8];
            2'h1: emitB = TPID[7:0];
            2'h2: emitB = tci[15:8];
            default: emitB = tci[7:0];
          endcase
        end else begin
          emitB = hdr[ecnt[3:0]];
        end
      end
      S_BODY: begin
        pop = adv && fifoValid;
        fire = pop && dcnt == DLY_FULL;
        emitB = dly[3];
      end
      S_FCS: begin
        fire = adv;
        emitB = fcsWord[{fcnt, 3'b000} +: 8];
      end
      default: begin
        fire = 1'b0;
      end
    endcase
    next_outValid = outValid && !outReady;
    next_outData = outData;
    next_outSop = outSop;
    next_outEop = outEop;
    if (fire) begin
      next_outValid = 1'b1;
      next_outData = emitB;
      next_outSop = (state == S_EMIT && ecnt == '0);
      next_outEop = (state == S_FCS && fcnt == FCS_LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outData <= '0;
      outSop <= 1'b0;
      outEop <= 1'b0;
      outPort <= '0;
    end else begin
      outValid <= next_outValid;
      outData <= next_outData;
      outSop <= next_outSop;
      outEop <= next_outEop;
      if (fire) begin
        outPort <= frmEg;
      end
    end
  end

  // header capture
  always_ff @(posedge clk) begin
    if (state == S_HDR && pop) begin
      if (fSop) begin
        hdr[0] <= fData;
        frmIn <= fifoWord[FW_IN_LSB +: PORT_W];
        frmEg <= fifoWord[FW_EG_LSB +: PORT_W];
      end else if (hcnt != '0) begin
        hdr[hcnt[3:0]] <= fData;
      end
    end
  end

  // body delay line holds back the old fcs
  always_ff @(posedge clk) begin
    if (state == S_BODY && pop) begin
      dly[0] <= fData;
      dly[1] <= dly[0];
      dly[2] <= dly[1];
      dly[3] <= dly[2];
    end
  end

  // frame sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_HDR;
      hcnt <= '0;
      ecnt <= '0;
      dcnt <= '0;
      fcnt <= '0;
      doStrip <= 1'b0;
      doInsert <= 1'b0;
      emitLen <= LEN_KEEP;
      frmVid <= DEFAULT_VID;
      frames <= '0;
      drops <= '0;
    end else begin
      case (state)
        S_HDR: begin
          if (pop) begin
            if (fEop) begin
              hcnt <= '0;
            end else if (fSop) begin
              hcnt <= 5'h01;
            end else if (hcnt == HDR_LAST) begin
              hcnt <= '0;
              state <= S_LOOK;
            end else if (hcnt != '0) begin
              hcnt <= hcnt + 1'b1;
            end
          end
        end
        S_LOOK: begin
          frmVid <= rxVid;
          doStrip <= rxTagged && rxUntag[frmEg];
          doInsert <= !rxTagged && !rxUntag[frmEg];
          if (rxTagged && rxUntag[frmEg]) begin
            emitLen <= LEN_STRIP;
          end else if (!rxTagged && !rxUntag[frmEg]) begin
            emitLen <= LEN_INSERT;
          end else begin
            emitLen <= LEN_KEEP;
          end
          ecnt <= '0;
          if (!rxMembers[frmEg]) begin
            state <= S_DROP;
            drops <= drops + 1'b1;
          end else begin
            state <= S_EMIT;
          end
        end
        S_EMIT: begin
          if (fire) begin
            ecnt <= ecnt + 1'b1;
            if (ecnt == emitLen - 1'b1) begin
              dcnt <= '0;
              state <= S_BODY;
            end
          end
        end
        S_BODY: begin
          if (pop) begin
            if (dcnt != DLY_FULL) begin
              dcnt <= dcnt + 1'b1;
            end
            if (fEop) begin
              fcnt <= '0;
              state <= S_FCS;
            end
          end
        end
        S_FCS: begin
          if (fire) begin
            fcnt <= fcnt + 1'b1;
            if (fcnt == FCS_LAST) begin
              frames <= frames + 1'b1;
              state <= S_HDR;
            end
          end
        end
        S_DROP: begin
          if (pop && fEop) begin
            state <= S_HDR;
          end
        end
        default: begin
          state <= S_HDR;
        end
      endcase
    end
  end

  chk_nonmember_drop: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_LOOK && !rxMembers[frmEg] |=> state == S_DROP && drops == $past(drops) + 1'b1)
    else $error("non-member frame not dropped");
  chk_untag_pvid: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_LOOK && {hdr[12], hdr[13]} != TPID |=> frmVid == $past(pvid[frmIn]))
    else $error("untagged frame not given port initial_vlan_group");
  chk_tag_vid: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_LOOK && {hdr[12], hdr[13]} == TPID |=> frmVid == {$past(hdr[14][3:0]), $past(hdr[15])})
    else $error("tagged frame vlan not taken from tag");
  chk_insert_tpid: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_EMIT && doInsert && fire && ecnt == SA_END |=> outValid && outData == 8'h81)
    else $error("tag type not after source address");
  chk_insert_tci: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_EMIT && doInsert && fire && ecnt == 5'h0E |=> outData[7:4] == 4'h0)
    else $error("inserted priority or cfi not zero");
  chk_fcs_end: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_FCS && fire && fcnt == FCS_LAST |=> outValid && outEop && state == S_HDR)
    else $error("recomputed fcs not closing frame");
  chk_reset_vlan: assert property (@(posedge clk)
    !rst_n |=> entValid[0] && entVid[0] == DEFAULT_VID && entMember[0] == RST_MEMBERS && pvid[0] == DEFAULT_VID)
    else $error("reset vlan table wrong");
  chk_create_prune: assert property (@(posedge clk) disable iff (!rst_n)
    createHit |=> (entMember[0] & $past(cfgWdata[ENT_MEMBER_LSB +: NPORTS])) == '0)
    else $error("new vlan ports still in vlan 1");
endmodule : vtcf_frame_proc

// [verif/vtcf_link_partner.sv]
// link partner model: byte source into the block, byte sink out of it
// assumes one clock; tb calls send right after a rising edge
module vtcf_link_partner
  import vtcf_pkg::*;
(
  input wire logic clk,
  output logic [7:0] inData,
  output logic inValid,
  output logic inSop,
  output logic inEop,
  output logic [PORT_W-1:0] inPort,
  output logic [PORT_W-1:0] inEgress,
  input wire logic inReady,
  input wire logic [7:0] outData,
  input wire logic outValid,
  input wire logic outEop,
  input wire logic [PORT_W-1:0] outPort,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxq[$];
  int eopCnt = 0;
  logic [PORT_W-1:0] lastPort = '0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic sawFull = 1'b0;
  initial begin
    {inData, inValid, inSop, inEop, inPort, inEgress, outReady} = '0;
  end
  // slow sink takes every other cycle, stall holds it off entirely
  always @(posedge clk) begin
    outReady <= !stall && (!slow || !outReady);
    if (outValid && outReady) begin
      rxq.push_back(outData);
      lastPort = outPort;
      if (outEop) begin
        eopCnt++;
      end
    end
    if (inValid && !inReady) begin
      sawFull <= 1'b1;
    end
  end
  task automatic send(input logic [7:0] q[$], input logic [PORT_W-1:0] p, input logic [PORT_W-1:0] e);
    for (int i = 0; i < q.size(); i++) begin
      inData <= q[i];
      inValid <= 1'b1;
      inSop <= (i == 0);
      inEop <= (i == q.size() - 1);
      inPort <= p;
      inEgress <= e;
      @(posedge clk);
      while (!inReady) begin
        @(posedge clk);
      end
    end
    inValid <= 1'b0;
    inSop <= 1'b0;
    inEop <= 1'b0;
    // released line shows no stale byte
    inData <= ~q[q.size() - 1];
    @(posedge clk);
  endtask : send
endmodule : vtcf_link_partner

// [verif/tb_top.sv]
// self-checking bench for the vlan classify/forward frame processor
// assumes the link partner model drives both streams; config by strobed port
module tb_top
  import vtcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] vtcf_bytes_t[$];
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] inData;
  logic [7:0] outData;
  logic inValid, inSop, inEop, inReady, outValid, outSop, outEop, outReady;
  logic [PORT_W-1:0] inPort, inEgress, outPort;
  logic [ADDR_W-1:0] cfgAddr = '0;
  logic [31:0] cfgWdata = '0;
  logic [31:0] cfgRdata;
  logic cfgWr = 1'b0;
  logic cfgRd = 1'b0;
  int failures = 0;
  int checked = 0;
  int sopSeen = 0;
  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (outValid && outReady && outSop) begin
      sopSeen++;
    end
  end

  vtcf_frame_proc i_dut (.clk(clk), .rst_n(rst_n), .inData(inData), .inValid(inValid), .inSop(inSop),
    .inEop(inEop), .inPort(inPort), .inEgress(inEgress), .inReady(inReady), .outData(outData),
    .outValid(outValid), .outSop(outSop), .outEop(outEop), .outPort(outPort), .outReady(outReady),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgWr(cfgWr), .cfgRd(cfgRd), .cfgRdata(cfgRdata));
  vtcf_link_partner lp (.clk(clk), .inData(inData), .inValid(inValid), .inSop(inSop), .inEop(inEop),
    .inPort(inPort), .inEgress(inEgress), .inReady(inReady), .outData(outData), .outValid(outValid),
    .outEop(outEop), .outPort(outPort), .outReady(outReady));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic cfg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    cfgAddr <= a;
    cfgWdata <= d;
    cfgWr <= 1'b1;
    @(posedge clk);
    cfgWr <= 1'b0;
    @(posedge clk);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    cfgAddr <= a;
    cfgRd <= 1'b1;
    @(posedge clk);
    cfgRd <= 1'b0;
    // data launched at the taking edge, sampled at the next one
    @(posedge clk);
    v = cfgRdata;
    @(posedge clk);
    // read data stands one cycle only
    check(cfgRdata, 32'h0);
  endtask : cfg_rd

  // frame with broadcast destination, optional tag, payload and crc-32 trailer
  function automatic vtcf_bytes_t mk(input logic tg, input logic [15:0] tci, input logic [15:0] et, input int n);
    vtcf_bytes_t q;
    logic [31:0] c;
    q = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    if (tg) begin
      q = {q, 8'h81, 8'h00, tci[15:8], tci[7:0]};
    end
    q = {q, et[15:8], et[7:0]};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'(i * 7 + 3));
    end
    c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      end
    end
    c = ~c;
    return {q, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction : mk

  task automatic expect_frame(input vtcf_bytes_t exp, input logic [PORT_W-1:0] eg);
    int n;
    n = 0;
    while (lp.eopCnt == 0 && n < 800) begin
      @(posedge clk);
      n++;
    end
    check(32'(lp.rxq.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      check(32'(lp.rxq[i]), 32'(exp[i]));
    end
    check(32'(lp.lastPort), 32'(eg));
    check(32'(sopSeen), 32'h1);
    sopSeen = 0;
    lp.rxq.delete();
    lp.eopCnt = 0;
  endtask : expect_frame

  task automatic t_reset();
    logic [31:0] v;
    cfg_rd(10'h100, v);
    check(v, 32'h80FF_0001);
    for (int p = 0; p < NPORTS; p++) begin
      cfg_rd(10'(p), v);
      check(v, 32'h1);
    end
    cfg_rd(10'h101, v);
    check(32'(v[31]), 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_plain();
    lp.send(mk(1'b0, 16'h0, 16'h88A8, 12), 2'h3, 2'h0);
    expect_frame(mk(1'b0, 16'h0, 16'h88A8, 12), 2'h0);
    $display("t_plain done");
  endtask : t_plain

  task automatic t_create();
    logic [31:0] v;
    cfg_wr(10'h101, 32'h8046_0005);
    cfg_wr(10'h000, 32'h5);
    cfg_wr(10'h1FE, 32'h8000_00FE);
    cfg_wr(10'h020, 32'hFFFF_FFFF);
    cfg_rd(10'h100, v);
    check(v, 32'h8099_0001);
    cfg_rd(10'h101, v);
    check(v, 32'h8046_0005);
    cfg_rd(10'h1FE, v);
    check(v, 32'h8000_00FE);
    cfg_rd(10'h000, v);
    check(v, 32'h5);
    cfg_rd(10'h020, v);
    check(v, 32'h0);
    $display("t_create done");
  endtask : t_create

  task automatic t_insert();
    lp.slow = 1'b1;
    lp.send(mk(1'b0, 16'h0, 16'h0800, 10), 2'h0, 2'h1);
    expect_frame(mk(1'b1, 16'h0005, 16'h0800, 10), 2'h1);
    lp.send(mk(1'b0, 16'h0, 16'h0800, 10), 2'h0, 2'h2);
    expect_frame(mk(1'b0, 16'h0, 16'h0800, 10), 2'h2);
    $display("t_insert done");
  endtask : t_insert

  task automatic t_strip();
    lp.send(mk(1'b1, 16'hB005, 16'h0800, 12), 2'h3, 2'h2);
    expect_frame(mk(1'b0, 16'h0, 16'h0800, 12), 2'h2);
    lp.send(mk(1'b1, 16'hB005, 16'h0800, 12), 2'h3, 2'h1);
    expect_frame(mk(1'b1, 16'hB005, 16'h0800, 12), 2'h1);
    lp.slow = 1'b0;
    $display("t_strip done");
  endtask : t_strip

  task automatic t_drop();
    logic [31:0] v;
    logic [15:0] tcis[4] = '{16'h0005, 16'h0000, 16'h0FFF, 16'h0006};
    logic [1:0] egs[4] = '{2'h0, 2'h1, 2'h1, 2'h1};
    // reserved id in a valid entry with all ports must still never match
    cfg_wr(10'h1FE, 32'h800F_0FFF);
    foreach (tcis[i]) begin
      lp.send(mk(1'b1, tcis[i], 16'h0800, 8), 2'h3, egs[i]);
    end
    lp.send(mk(1'b0, 16'h0, 16'h0800, 8), 2'h0, 2'h3);
    repeat (80) @(posedge clk);
    check(32'(lp.rxq.size()), 32'h0);
    cfg_rd(ADDR_DROPS, v);
    check(v, 32'h5);
    cfg_rd(ADDR_FRAMES, v);
    check(v, 32'h5);
    $display("t_drop done");
  endtask : t_drop

  task automatic t_fifo();
    lp.stall = 1'b1;
    fork
      lp.send(mk(1'b0, 16'h0, 16'h0800, 30), 2'h3, 2'h3);
      begin
        repeat (60) @(posedge clk);
        // fifo must have refused while the sink stalled
        check(32'(lp.sawFull), 32'h1);
        lp.stall = 1'b0;
      end
    join
    expect_frame(mk(1'b0, 16'h0, 16'h0800, 30), 2'h3);
    check(32'(inReady), 32'h1);
    $display("t_fifo done");
  endtask : t_fifo

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_plain();
    t_create();
    t_insert();
    t_strip();
    t_drop();
    t_fifo();
    print_verdict();
  end

  // whole run takes under a thousand cycles
  initial begin
    #(20000 * 50);
    failures++;
    print_verdict();
  end
endmodule : tb_top
